// ### fxd_cfg.svh
// Constants of the floating-point exception dispatch block.
// Functional notes
// RL1 - Undefined opcode raises vector 6 fault.
// RL2 - Task-switched or emulate flag raises vector 7.
// RL3 - Undefined opcode skips pending error check.
// RL4 - Errors reported directly, error pin for legacy.
// RL5 - External controller turns error pin into interrupt.
// RL6 - Primary variant: error pin at completion.
// RL7 - Alternative variant: pin deferred, next op blocked.
// RL8 - Denormal operands normalized, never invalid-operation.
// RL9 - Misaligned operand at level 3 faults.
// RL10 - Environment load probes both ends first.
// RL11 - Never vector 9; abort instead.
// RL12 - Operand beyond segment limit raises vector 13.
// RL13 - Error fault uses vector 16.
// RL14 - Tiny result from denormal ops signals underflow.
// RL15 - Error pin holds until flags cleared.
`ifndef FXD_CFG_SVH
`define FXD_CFG_SVH
`define FXD_VEC_UD       8'h06
`define FXD_VEC_NM       8'h07
`define FXD_VEC_NP       8'h0b
`define FXD_VEC_OVERRUN  8'h09
`define FXD_VEC_GP       8'h0d
`define FXD_VEC_MF       8'h10
`define FXD_VEC_AC       8'h11
`define FXD_USER_CPL     2'h3
`define FXD_REG_CTRL     8'h00
`define FXD_REG_STATUS   8'h04
`define FXD_REG_MASK     8'h08
`define FXD_REG_FLAGS    8'h0c
`define FXD_REG_FMASK    8'h10
`define FXD_REG_STATE    8'h14
`define FXD_CTRL_ALT     0
`define FXD_CTRL_EARLY   1
`define FXD_FLAG_INV     0
`define FXD_FMASK_RESET  6'h3f
`define FXD_EV_UD        0
`define FXD_EV_NM        1
`define FXD_EV_GP        2
`define FXD_EV_AC        3
`define FXD_EV_MF        4
`define FXD_EV_NP        5
`define FXD_EV_ABORT     6
`define FXD_EV_UFL       7
`endif

// ### fxd_pkg.sv
// Types shared by the floating-point exception dispatch block.
`default_nettype none
package fxd_pkg;
  typedef enum logic [3:0] {
    FXD_OP_OTHER    = 4'h0,
    FXD_OP_SQRT     = 4'h1,
    FXD_OP_DIV      = 4'h2,
    FXD_OP_PREM     = 4'h3,
    FXD_OP_CONV     = 4'h4,
    FXD_OP_ENV_LOAD = 4'h5,
    FXD_OP_SAVE     = 4'h6,
    FXD_OP_XSAVE    = 4'h7,
    FXD_OP_RESTORE  = 4'h8,
    FXD_OP_XRESTORE = 4'h9
  } fxd_op_t;
  typedef enum logic [1:0] {
    FXD_IDLE = 2'b00,
    FXD_ENV  = 2'b01,
    FXD_EXEC = 2'b10
  } fxd_state_t;
  typedef enum logic [1:0] {
    FXD_PR_IDLE  = 2'b00,
    FXD_PR_FIRST = 2'b01,
    FXD_PR_LAST  = 2'b10
  } fxd_probe_t;
endpackage : fxd_pkg
`default_nettype wire

// ### fxd_env_probe.sv
// Reads the first and last byte of an environment image before any update.
`timescale 1ns/1ns
`default_nettype none
module fxd_env_probe (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Request
  input  wire logic        start,
  input  wire logic [31:0] first_addr,
  input  wire logic [31:0] last_addr,
  // Memory probe
  output logic             probe_req,
  output logic      [31:0] probe_addr,
  input  wire logic        probe_ack,
  input  wire logic        probe_absent,
  // Result
  output logic             done,
  output logic             absent
);
  import fxd_pkg::*;
  fxd_probe_t  state;
  fxd_probe_t  next_state;
  logic [31:0] last_q;
  wire         ack_ok   = probe_ack & ~probe_absent;
  wire         ack_bad  = probe_ack & probe_absent;
  always_comb begin
    next_state = state;
    case (state)
      FXD_PR_IDLE:  if (start) next_state = FXD_PR_FIRST;
      FXD_PR_FIRST: if (ack_bad) next_state = FXD_PR_IDLE;
                    else if (ack_ok) next_state = FXD_PR_LAST;
      FXD_PR_LAST:  if (probe_ack) next_state = FXD_PR_IDLE;
      default:      next_state = FXD_PR_IDLE;
    endcase
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state      <= FXD_PR_IDLE;
      probe_addr <= 32'h0;
      last_q     <= 32'h0;
      done       <= 1'b0;
      absent     <= 1'b0;
    end else begin
      state  <= next_state;
      done   <= probe_ack & (ack_bad | state == FXD_PR_LAST);
      absent <= ack_bad;
      if (start && state == FXD_PR_IDLE) begin
        probe_addr <= first_addr;
        last_q     <= last_addr;
      end else if (ack_ok && state == FXD_PR_FIRST) begin
        probe_addr <= last_q;
      end
    end
  end
  // Both ends are touched before the caller may commit anything.
  assign probe_req = (state != FXD_PR_IDLE); // RL10
endmodule : fxd_env_probe
`default_nettype wire

// ### fxd_dispatch.sv
// Exception selection, error pin and event registers of the floating-point unit.
`timescale 1ns/1ns
`default_nettype none
`include "fxd_cfg.svh"
module fxd_dispatch (
  // Clock and reset
  input  wire logic           clk,
  input  wire logic           rst_n,
  // Register port
  input  wire logic     [7:0] reg_addr,
  input  wire logic    [31:0] reg_wdata,
  input  wire logic           reg_wr,
  input  wire logic           reg_rd,
  output logic         [31:0] reg_rdata,
  // Core state
  input  wire logic           task_switched_flag,
  input  wire logic           emulate_fpu_flag,
  input  wire logic           align_check_en,
  input  wire logic     [1:0] cpl,
  // Instruction issue
  input  wire logic           op_valid,
  output logic                op_ready,
  input  wire logic           op_defined,
  input  wire fxd_pkg::fxd_op_t op_class,
  input  wire logic           op_denorm,
  input  wire logic           mem_misaligned,
  input  wire logic           mem_stack_part,
  input  wire logic           mem_beyond_limit,
  input  wire logic           mem_overrun,
  input  wire logic    [31:0] env_first_addr,
  input  wire logic    [31:0] env_last_addr,
  // Environment probe
  output logic                probe_req,
  output logic         [31:0] probe_addr,
  input  wire logic           probe_ack,
  input  wire logic           probe_absent,
  // Completion
  input  wire logic           op_done,
  input  wire logic     [5:0] done_flags,
  input  wire logic           done_denorm_inv,
  input  wire logic           done_tiny,
  // Dispatch answers
  output logic                fault_valid,
  output logic          [7:0] fault_vector,
  output logic                op_go,
  output logic                op_abort,
  output logic                normalize_req,
  output logic                env_commit,
  // Error pin and interrupt
  output logic                fp_error_out_n,
  output logic                irq
);
  import fxd_pkg::*;

  fxd_state_t state;
  fxd_state_t next_state;
  fxd_op_t    exec_class;
  logic [1:0] ctrl;
  logic [7:0] status;
  logic [7:0] irq_mask;
  logic [5:0] fp_flags;
  logic [5:0] fp_mask;
  logic       alt_armed;
  logic       err;
  logic       pr_done;
  logic       pr_absent;

  // Register decode.
  wire wr_ctrl   = reg_wr & (reg_addr == `FXD_REG_CTRL);
  wire wr_status = reg_wr & (reg_addr == `FXD_REG_STATUS);
  wire wr_mask   = reg_wr & (reg_addr == `FXD_REG_MASK);
  wire wr_flags  = reg_wr & (reg_addr == `FXD_REG_FLAGS);
  wire wr_fmask  = reg_wr & (reg_addr == `FXD_REG_FMASK);
  wire alt_mode  = ctrl[`FXD_CTRL_ALT];
  wire alt_early = ctrl[`FXD_CTRL_EARLY];

  // Issue decode, in priority order.
  wire issue    = op_valid & op_ready;
  wire pend     = |(fp_flags & ~fp_mask);
  wire nm_hit   = task_switched_flag | emulate_fpu_flag; // RL2
  wire ud_hit   = ~nm_hit & ~op_defined; // RL1
  // Pending errors are looked at only for defined opcodes.
  wire mf_hit   = ~nm_hit & op_defined & pend; // RL3 RL13
  wire gp_hit   = ~nm_hit & op_defined & ~pend & mem_beyond_limit; // RL12
  wire save_rst = (op_class == FXD_OP_SAVE) | (op_class == FXD_OP_XSAVE) |
                  (op_class == FXD_OP_RESTORE) | (op_class == FXD_OP_XRESTORE);
  wire ac_cond  = align_check_en & (cpl == `FXD_USER_CPL) & mem_misaligned &
                  ~(mem_stack_part & save_rst);
  wire ac_hit   = ~nm_hit & op_defined & ~pend & ~mem_beyond_limit & ac_cond; // RL9
  wire any_hit  = nm_hit | ud_hit | mf_hit | gp_hit | ac_hit;
  wire ovr_hit  = ~any_hit & mem_overrun; // RL11
  wire env_op   = (op_class == FXD_OP_ENV_LOAD);
  wire start_ok = issue & ~any_hit & ~ovr_hit;
  wire norm_cls = (op_class == FXD_OP_SQRT) | (op_class == FXD_OP_DIV) |
                  (op_class == FXD_OP_PREM) | (op_class == FXD_OP_CONV);
  wire [7:0] vec_sel = nm_hit ? `FXD_VEC_NM :
                       ud_hit ? `FXD_VEC_UD :
                       mf_hit ? `FXD_VEC_MF :
  // Alignment faults rank last among the faults, so they are the fallback of the selector.
                       gp_hit ? `FXD_VEC_GP : `FXD_VEC_AC;

  // Completion: denormal invalid is dropped for normalizing classes.
  wire ex_norm   = (exec_class == FXD_OP_SQRT) | (exec_class == FXD_OP_DIV) |
                   (exec_class == FXD_OP_PREM) | (exec_class == FXD_OP_CONV);
  wire ex_ufl    = (exec_class == FXD_OP_SQRT) | (exec_class == FXD_OP_DIV) |
                   (exec_class == FXD_OP_PREM);
  wire done_ok   = op_done & (state == FXD_EXEC);
  wire drop_inv  = ex_norm & done_denorm_inv; // RL8
  wire [5:0] inv_clr = {5'h00, drop_inv};
  wire [5:0] done_set = done_ok ? (done_flags & ~inv_clr) : 6'h00;
  wire ufl_ev    = done_ok & ex_ufl & done_tiny; // RL14

  // Event vector feeding the sticky status bits.
  wire [7:0] ev;
  assign ev[`FXD_EV_UD]    = issue & ud_hit;
  assign ev[`FXD_EV_NM]    = issue & nm_hit;
  assign ev[`FXD_EV_GP]    = issue & gp_hit;
  assign ev[`FXD_EV_AC]    = issue & ac_hit;
  assign ev[`FXD_EV_MF]    = issue & mf_hit;
  assign ev[`FXD_EV_NP]    = pr_done & pr_absent;
  assign ev[`FXD_EV_ABORT] = issue & ovr_hit;
  assign ev[`FXD_EV_UFL]   = ufl_ev;

  wire [7:0] next_status = (status & ~(wr_status ? reg_wdata[7:0] : 8'h00)) | ev;
  wire [5:0] next_flags  = (fp_flags & ~(wr_flags ? reg_wdata[5:0] : 6'h00)) | done_set;

  // In the alternative variant the pin waits for the next issue attempt.
  // Arming looks at the flags as they stand after this edge, so that a completion which
  // raises an unmasked flag can arm the early variant in its own cycle.
  wire next_pend  = |(next_flags & ~(wr_fmask ? reg_wdata[5:0] : fp_mask));
  wire next_armed = next_pend & (alt_armed | issue | (done_ok & alt_early));
  wire next_err   = pend & (~alt_mode | alt_armed); // RL6 RL7 RL15

  wire [31:0] rd_mux =
    (reg_addr == `FXD_REG_CTRL)   ? {30'h0, ctrl} :
    (reg_addr == `FXD_REG_STATUS) ? {24'h0, status} :
    (reg_addr == `FXD_REG_MASK)   ? {24'h0, irq_mask} :
    (reg_addr == `FXD_REG_FLAGS)  ? {26'h0, fp_flags} :
    (reg_addr == `FXD_REG_FMASK)  ? {26'h0, fp_mask} :
    (reg_addr == `FXD_REG_STATE)  ? {28'h0, err, alt_armed, state} : 32'h0;

  always_comb begin
    next_state = state;
    case (state)
      FXD_IDLE: if (start_ok) next_state = env_op ? FXD_ENV : FXD_EXEC;
      FXD_ENV:  if (pr_done) next_state = pr_absent ? FXD_IDLE : FXD_EXEC;
      FXD_EXEC: if (op_done) next_state = FXD_IDLE;
      default:  next_state = FXD_IDLE;
    endcase
  end

  assign op_ready = (state == FXD_IDLE);

  // Probing runs before any commit, so a missing segment leaves the unit state untouched.
  fxd_env_probe u_probe (
    .clk          (clk),
    .rst_n        (rst_n),
    .start        (start_ok & env_op),
    .first_addr   (env_first_addr),
    .last_addr    (env_last_addr),
    .probe_req    (probe_req),
    .probe_addr   (probe_addr),
    .probe_ack    (probe_ack),
    .probe_absent (probe_absent),
    .done         (pr_done),
    .absent       (pr_absent)
  );

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state      <= FXD_IDLE;
      exec_class <= FXD_OP_OTHER;
    end else begin
      state <= next_state;
      if (start_ok) exec_class <= op_class;
    end
  end

  // Dispatch answers from flops; all but fault_vector are one-cycle pulses, the vector holds its value.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fault_valid   <= 1'b0;
      fault_vector  <= 8'h00;
      op_go         <= 1'b0;
      op_abort      <= 1'b0;
      normalize_req <= 1'b0;
      env_commit    <= 1'b0;
    end else begin
      fault_valid   <= (issue & any_hit) | ev[`FXD_EV_NP];
      if (issue & any_hit) fault_vector <= vec_sel;
      if (ev[`FXD_EV_NP]) fault_vector <= `FXD_VEC_NP;
      // Overrun cases without another fault end as an abort, never as a fault.
      op_abort      <= issue & ovr_hit; // RL11
      op_go         <= (start_ok & ~env_op) | (pr_done & ~pr_absent);
      normalize_req <= start_ok & norm_cls & op_denorm; // RL8
      env_commit    <= pr_done & ~pr_absent; // RL10
    end
  end

  // Registers, events and error pin.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl      <= 2'h0;
      status    <= 8'h00;
      irq_mask  <= 8'h00;
      fp_flags  <= 6'h00;
      fp_mask   <= `FXD_FMASK_RESET;
      alt_armed <= 1'b0;
      err       <= 1'b0;
      reg_rdata <= 32'h0;
    end else begin
      if (wr_ctrl)  ctrl     <= reg_wdata[1:0];
      if (wr_mask)  irq_mask <= reg_wdata[7:0];
      if (wr_fmask) fp_mask  <= reg_wdata[5:0];
      status    <= next_status;
      fp_flags  <= next_flags;
      alt_armed <= next_armed;
      err       <= next_err;
      reg_rdata <= reg_rd ? rd_mux : 32'h0;
    end
  end

  // The pin reaches an outside controller; internally only the state register reads back its flop.
  assign fp_error_out_n = ~err; // RL4 RL5
  assign irq            = |(status & irq_mask);

  // Checks.
  sequence s_issue_nm;
    issue & nm_hit;
  endsequence
  sequence s_vec(logic [7:0] v);
    fault_valid & (fault_vector == v);
  endsequence
  // The pin flop is written one edge after the arming edge, so the pin shows low one more on.
  sequence s_pin_low;
    ##1 !fp_error_out_n;
  endsequence

  // Fault selection at issue.
  chk_nm_vector: assert property (@(posedge clk) disable iff (!rst_n) // RL2
    s_issue_nm |=> s_vec(`FXD_VEC_NM) and !op_go)
    else $error("unit unavailable not on vector 7");

  chk_ud_vector: assert property (@(posedge clk) disable iff (!rst_n) // RL1
    issue & ~nm_hit & ~op_defined |=> s_vec(`FXD_VEC_UD))
    else $error("undefined opcode not on vector 6");

  chk_ud_no_error: assert property (@(posedge clk) disable iff (!rst_n) // RL3
    issue & ~nm_hit & ~op_defined & pend |=> !status[`FXD_EV_MF] || $past(status[`FXD_EV_MF]))
    else $error("error check made for undefined opcode");

  chk_gp_vector: assert property (@(posedge clk) disable iff (!rst_n) // RL12
    issue & ~nm_hit & op_defined & ~pend & mem_beyond_limit |=> s_vec(`FXD_VEC_GP))
    else $error("limit fault not on vector 13");

  chk_mf_vector: assert property (@(posedge clk) disable iff (!rst_n) // RL13
    issue & ~nm_hit & op_defined & pend |=> s_vec(`FXD_VEC_MF) and !op_go)
    else $error("error fault not on vector 16");

  chk_no_overrun: assert property (@(posedge clk) disable iff (!rst_n) // RL11
    !(fault_valid && fault_vector == `FXD_VEC_OVERRUN))
    else $error("vector 9 raised");

  chk_overrun_abort: assert property (@(posedge clk) disable iff (!rst_n) // RL11
    issue & ovr_hit |=> op_abort & !op_go & !fault_valid)
    else $error("overrun did not abort");

  // Error pin, blocking, alignment, environment atomicity, underflow and denormal invalid.
  chk_err_primary: assert property (@(posedge clk) disable iff (!rst_n) // RL6
    done_ok & ~alt_mode & |(done_flags & ~fp_mask & 6'h3e) & ~wr_flags & ~wr_fmask
      & ~wr_ctrl |=> ##1 !fp_error_out_n)
    else $error("error pin late after completion");

  chk_err_release: assert property (@(posedge clk) disable iff (!rst_n) // RL15
    !pend |=> fp_error_out_n)
    else $error("error pin held after clear");

  chk_alt_block: assert property (@(posedge clk) disable iff (!rst_n) // RL7
    issue & op_defined & ~nm_hit & pend |=> !op_go ##1 !op_go)
    else $error("instruction ran with pending error");

  chk_ac_fault: assert property (@(posedge clk) disable iff (!rst_n) // RL9
    issue & ac_hit |=> fault_valid & (fault_vector == `FXD_VEC_AC) & status[`FXD_EV_AC])
    else $error("alignment fault missing");

  chk_env_atomic: assert property (@(posedge clk) disable iff (!rst_n) // RL10
    state == FXD_ENV & probe_ack & probe_absent |=> !env_commit [*3])
    else $error("environment committed after absent segment");

  chk_ufl_event: assert property (@(posedge clk) disable iff (!rst_n) // RL14
    ufl_ev |=> status[`FXD_EV_UFL])
    else $error("underflow not signalled");

  chk_denorm_inv: assert property (@(posedge clk) disable iff (!rst_n) // RL8
    done_ok & drop_inv & ~fp_flags[`FXD_FLAG_INV] |=> !fp_flags[`FXD_FLAG_INV])
    else $error("invalid raised on denormal");

  // Alternative variant of the pin.
  chk_early_pin: assert property (@(posedge clk) disable iff (!rst_n) // RL7
    done_ok & alt_mode & alt_early & |(done_set & ~fp_mask) & ~wr_flags & ~wr_fmask
      & ~wr_ctrl |=> s_pin_low)
    else $error("early variant pin not asserted");

  chk_alt_arm: assert property (@(posedge clk) disable iff (!rst_n) // RL7
    issue & alt_mode & pend & ~wr_flags & ~wr_fmask |=> s_pin_low)
    else $error("pin not asserted before next instruction");

  chk_alt_hold: assert property (@(posedge clk) disable iff (!rst_n) // RL7
    alt_mode & ~alt_armed |=> fp_error_out_n)
    else $error("pin asserted before arming");

  // Environment load.
  chk_probe_first: assert property (@(posedge clk) disable iff (!rst_n) // RL10
    start_ok & env_op |=> probe_req & (probe_addr == $past(env_first_addr)) & !env_commit)
    else $error("environment load did not probe first byte");

  chk_env_commit: assert property (@(posedge clk) disable iff (!rst_n) // RL10
    pr_done & ~pr_absent |=> env_commit & op_go)
    else $error("environment not committed after probes");

  chk_np_vector: assert property (@(posedge clk) disable iff (!rst_n) // RL10
    pr_done & pr_absent |=> s_vec(`FXD_VEC_NP) and !env_commit)
    else $error("absent segment not faulted");

  // Event bits and normalization.
  chk_norm_req: assert property (@(posedge clk) disable iff (!rst_n) // RL8
    start_ok & norm_cls & op_denorm |=> normalize_req & op_go)
    else $error("denormal operand not normalized");

  chk_ud_status: assert property (@(posedge clk) disable iff (!rst_n) // RL1
    issue & ud_hit |=> status[`FXD_EV_UD])
    else $error("undefined opcode event lost");

  chk_nm_status: assert property (@(posedge clk) disable iff (!rst_n) // RL2
    issue & nm_hit |=> status[`FXD_EV_NM])
    else $error("unit unavailable event lost");

  chk_mf_status: assert property (@(posedge clk) disable iff (!rst_n) // RL13
    issue & mf_hit |=> status[`FXD_EV_MF])
    else $error("error fault event lost");

  chk_abort_status: assert property (@(posedge clk) disable iff (!rst_n) // RL11
    issue & ovr_hit |=> status[`FXD_EV_ABORT])
    else $error("abort event lost");
endmodule : fxd_dispatch
`default_nettype wire

// ### fxd_far_model.sv
// Far-side model: legacy interrupt controller and environment image memory.
`timescale 1ns/1ns
`default_nettype none
module fxd_far_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Error pin and interrupt
  input  wire logic        fp_error_out_n,
  output logic             maskable_irq_in,
  // Environment probe
  input  wire logic        probe_req,
  input  wire logic [31:0] probe_addr,
  output logic             probe_ack,
  output logic             probe_absent,
  // Behaviour controls
  input  wire logic        slow,
  input  wire logic [31:0] absent_addr
);
  logic [1:0] wait_cnt;
  logic       ack_now;

  assign ack_now = probe_req && !probe_ack && (wait_cnt == (slow ? 2'h3 : 2'h0));
  // While a slow answer waits, the absent line toggles with wait_cnt[0], so a design that looks at it early is caught.
  assign probe_absent = probe_ack ? (probe_addr == absent_addr) : wait_cnt[0];

  // The controller turns a low error pin into the core's maskable interrupt.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      maskable_irq_in <= 1'b0;
    end else begin
      maskable_irq_in <= !fp_error_out_n;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wait_cnt  <= 2'h0;
      probe_ack <= 1'b0;
    end else begin
      probe_ack <= ack_now;
      if (ack_now || !probe_req) begin
        wait_cnt <= 2'h0;
      end else begin
        wait_cnt <= wait_cnt + 2'h1;
      end
    end
  end
endmodule : fxd_far_model
`default_nettype wire

// ### test_fxd_dispatch.sv
// Self-checking testbench of the floating-point exception dispatch block.
`timescale 1ns/1ns
`default_nettype none
`include "fxd_cfg.svh"
module test_fxd_dispatch;
  import fxd_pkg::*;
  logic        clk, rst_n, reg_wr, reg_rd, ts, em, ac_en, op_valid, op_ready, op_defined;
  logic        op_denorm, mis, stk, beyond, ovr, probe_req, probe_ack, probe_absent, op_done;
  logic        dinv, tiny, fault_valid, op_go, op_abort, norm, env_commit, err_n, irq;
  logic        int_req, slow;
  logic [1:0]  cpl;
  logic [3:0]  ans;
  logic [5:0]  done_flags;
  logic [7:0]  reg_addr, fault_vector, vec;
  logic [31:0] reg_wdata, reg_rdata, probe_addr, absent_addr, env_first, env_last;
  fxd_op_t     op_class;
  logic [31:0] plog[$];
  int          err_total, check_count, ncommit;
  logic [7:0]  raddr[7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h20};
  logic [31:0] rexp[7] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h3f, 32'h0, 32'h0};
  fxd_op_t     dops[4] = '{FXD_OP_SQRT, FXD_OP_DIV, FXD_OP_PREM, FXD_OP_CONV};

  fxd_dispatch DUT (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .task_switched_flag(ts),
    .emulate_fpu_flag(em), .align_check_en(ac_en), .cpl(cpl), .op_valid(op_valid),
    .op_ready(op_ready), .op_defined(op_defined), .op_class(op_class), .op_denorm(op_denorm),
    .mem_misaligned(mis), .mem_stack_part(stk), .mem_beyond_limit(beyond), .mem_overrun(ovr),
    .env_first_addr(env_first), .env_last_addr(env_last), .probe_req(probe_req),
    .probe_addr(probe_addr), .probe_ack(probe_ack), .probe_absent(probe_absent),
    .op_done(op_done), .done_flags(done_flags), .done_denorm_inv(dinv), .done_tiny(tiny),
    .fault_valid(fault_valid), .fault_vector(fault_vector), .op_go(op_go), .op_abort(op_abort),
    .normalize_req(norm), .env_commit(env_commit), .fp_error_out_n(err_n), .irq(irq));

  fxd_far_model far (.clk(clk), .rst_n(rst_n), .fp_error_out_n(err_n), .maskable_irq_in(int_req),
    .probe_req(probe_req), .probe_addr(probe_addr), .probe_ack(probe_ack),
    .probe_absent(probe_absent), .slow(slow), .absent_addr(absent_addr));

  always #25 clk = ~clk;

  always @(posedge clk) begin
    if (probe_ack === 1'b1) plog.push_back(probe_addr);
    if (env_commit === 1'b1) ncommit++;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic complete_run;
    $display("Checks made %0d, mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : complete_run

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, e);
  endtask : rd_chk

  // Qualifiers q: {cpl[1:0], ts, em, ac_en, denorm, misaligned, stack, beyond, overrun}.
  task automatic issue(input logic d, input fxd_op_t c, input logic [9:0] q);
    @(posedge clk);
    op_valid <= 1'b1;
    op_defined <= d;
    op_class <= c;
    {cpl, ts, em, ac_en, op_denorm, mis, stk, beyond, ovr} <= q;
    @(posedge clk);
    op_valid <= 1'b0;
    #1;
    ans = {fault_valid, op_abort, op_go, norm};
    vec = fault_vector;
  endtask : issue

  task automatic done_op(input logic [5:0] f, input logic [1:0] dt);
    @(posedge clk);
    op_done <= 1'b1;
    done_flags <= f;
    {dinv, tiny} <= dt;
    @(posedge clk);
    op_done <= 1'b0;
  endtask : done_op

  // Bounded wait: 0 commit, 1 fault, 2 error pin low, 3 controller interrupt.
  task automatic wait_for(input int sel);
    for (int n = 0; n < 30; n++) begin
      @(posedge clk);
      #1;
      if (sel == 0 ? env_commit === 1'b1 : sel == 1 ? fault_valid === 1'b1 :
          sel == 2 ? err_n === 1'b0 : int_req === 1'b1) return;
    end
    err_total++;
    complete_run();
  endtask : wait_for

  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    {reg_wr, reg_rd, op_valid, op_defined, op_done, dinv, tiny, slow} = 8'h00;
    {cpl, ts, em, ac_en, op_denorm, mis, stk, beyond, ovr} = 10'h000;
    {reg_addr, reg_wdata, done_flags} = '0;
    op_class = FXD_OP_OTHER;
    env_first = 32'h00000100;
    env_last = 32'h0000011b;
    absent_addr = 32'hffffffff;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 7; i++) rd_chk(raddr[i], rexp[i]);
    wr_reg(`FXD_REG_MASK, 32'hff);
    issue(1'b0, FXD_OP_OTHER, 10'h000);
    chk({ans, vec}, 12'h806);
    chk(irq, 1'b1);
    issue(1'b1, FXD_OP_OTHER, 10'h080);
    chk({ans, vec}, 12'h807);
    issue(1'b0, FXD_OP_OTHER, 10'h040);
    chk({ans, vec}, 12'h807);
    rd_chk(`FXD_REG_STATUS, 32'h03);
    wr_reg(`FXD_REG_MASK, 32'h00);
    #1 chk(irq, 1'b0);
    wr_reg(`FXD_REG_MASK, 32'hff);
    wr_reg(`FXD_REG_STATUS, 32'h03);
    #1 chk(irq, 1'b0);
    issue(1'b1, FXD_OP_OTHER, 10'h002);
    chk({ans, vec}, 12'h80d);
    issue(1'b1, FXD_OP_OTHER, 10'h328);
    chk({ans, vec}, {4'h8, `FXD_VEC_AC});
    issue(1'b1, FXD_OP_OTHER, 10'h028);
    chk(ans, 4'h2);
    done_op(6'h00, 2'h0);
    issue(1'b1, FXD_OP_SAVE, 10'h32c);
    chk(ans, 4'h2);
    done_op(6'h00, 2'h0);
    issue(1'b1, FXD_OP_OTHER, 10'h001);
    chk(ans, 4'h4);
    rd_chk(`FXD_REG_STATUS, 32'h4c);
    wr_reg(`FXD_REG_STATUS, 32'hff);
    foreach (dops[i]) begin
      issue(1'b1, dops[i], 10'h010);
      chk(ans, 4'h3);
      done_op(6'h01, 2'h2);
    end
    rd_chk(`FXD_REG_FLAGS, 32'h00);
    issue(1'b1, FXD_OP_DIV, 10'h010);
    done_op(6'h10, 2'h1);
    rd_chk(`FXD_REG_STATUS, 32'h80);
    wr_reg(`FXD_REG_FLAGS, 32'h3f);
    wr_reg(`FXD_REG_STATUS, 32'hff);
    wr_reg(`FXD_REG_FMASK, 32'h00);
    issue(1'b1, FXD_OP_DIV, 10'h000);
    done_op(6'h04, 2'h0);
    #1 chk(err_n, 1'b1);
    @(posedge clk);
    #1 chk(err_n, 1'b0);
    wait_for(3);
    issue(1'b0, FXD_OP_OTHER, 10'h000);
    chk(vec, 8'h06);
    issue(1'b1, FXD_OP_OTHER, 10'h000);
    chk({ans, vec}, 12'h810);
    wr_reg(`FXD_REG_FLAGS, 32'h04);
    @(posedge clk);
    #1 chk(err_n, 1'b1);
    wr_reg(`FXD_REG_CTRL, 32'h01);
    issue(1'b1, FXD_OP_DIV, 10'h000);
    done_op(6'h04, 2'h0);
    repeat (3) @(posedge clk);
    #1 chk(err_n, 1'b1);
    issue(1'b1, FXD_OP_OTHER, 10'h000);
    chk({ans, vec}, 12'h810);
    wait_for(2);
    wr_reg(`FXD_REG_FLAGS, 32'h04);
    wr_reg(`FXD_REG_CTRL, 32'h03);
    issue(1'b1, FXD_OP_DIV, 10'h000);
    done_op(6'h04, 2'h0);
    wait_for(2);
    wr_reg(`FXD_REG_FLAGS, 32'h04);
    wr_reg(`FXD_REG_CTRL, 32'h00);
    plog.delete();
    issue(1'b1, FXD_OP_ENV_LOAD, 10'h000);
    chk({ans, op_ready}, 5'h00);
    wait_for(0);
    chk(plog.size(), 32'd2);
    chk(plog[0], env_first);
    chk(plog[1], env_last);
    done_op(6'h00, 2'h0);
    @(posedge clk);
    slow <= 1'b1;
    absent_addr <= env_last;
    plog.delete();
    ncommit = 0;
    issue(1'b1, FXD_OP_ENV_LOAD, 10'h000);
    wait_for(1);
    chk(fault_vector, `FXD_VEC_NP);
    chk(ncommit, 32'd0);
    chk(plog.size(), 32'd2);
    complete_run();
  end
endmodule : test_fxd_dispatch
`default_nettype wire
